// *** src/sbcwk_regs.vh ***
// register map, field positions, reset values and timing figures
`ifndef SBCWK_REGS_VH
`define SBCWK_REGS_VH

// ------------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define SBCWK_IDX_MODE      3'h0
`define SBCWK_IDX_RSTCTL    3'h1
`define SBCWK_IDX_CAN       3'h2
`define SBCWK_IDX_IO        3'h3
`define SBCWK_IDX_WAKE      3'h4
`define SBCWK_IDX_WDTIM     3'h5
`define SBCWK_IDX_LOWPWR    3'h6
`define SBCWK_IDX_INT       3'h7
`define SBCWK_ADR_W         8
`define SBCWK_DW            4

// ------------------------------------------------------------------
// mode control write codes
// ------------------------------------------------------------------
`define SBCWK_MC_DEBUG      3'h0
`define SBCWK_MC_NORMAL     3'h1
`define SBCWK_MC_STANDBY    3'h2
`define SBCWK_MC_STOP       3'h3
`define SBCWK_MC_SLEEP      3'h4
`define SBCWK_MC_DBG_NORMAL 3'h5
`define SBCWK_MC_DBG_STBY   3'h6
`define SBCWK_MC_DBG_STOP   3'h7

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define SBCWK_LP_CS_BIT     0
`define SBCWK_LP_FWU_BIT    1
`define SBCWK_IO_HS_BIT     2
`define SBCWK_RC_WDSTOP_BIT 3
`define SBCWK_INT_EW_BIT    0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SBCWK_RST_WDSTOP    1'b1
`define SBCWK_RST_BATTERY_FAIL_FLAG   1'b1
`define SBCWK_RST_GSEL      2'h0

// ------------------------------------------------------------------
// timing figures
// ------------------------------------------------------------------
`define SBCWK_CLK_KHZ       125000
`define SBCWK_T_RST_MS      1
`define SBCWK_T_NREQ_MS     350
`define SBCWK_T_WD_MS       350
`define SBCWK_T_FWU_MS      200
`define SBCWK_T_CS_PER_MS   50
`define SBCWK_T_CS_ON_MS    1

`endif

// *** src/sbcwk_sync.v ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sbcwk_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // pins in, synchronised out
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (rst_i) begin
                    stage1[g] <= 1'b0;
                    stage2[g] <= 1'b0;
                end else begin
                    stage1[g] <= d_i[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign q_o = stage2;
endmodule // sbcwk_sync

// *** src/sbcwk_timer.v ***
// restartable cycle counter that flags when its limit is reached
`timescale 1ns/1ps
module sbcwk_timer (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // control
    input  wire        restart_i,
    input  wire        run_i,
    input  wire [31:0] limit_i,
    // status
    output wire [31:0] count_o,
    output wire        done_o
);
    reg [31:0] count;

    assign done_o  = (count == limit_i);
    assign count_o = count;

    always @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count <= 32'h0;
        end else if (run_i && !done_o) begin
            count <= count + 32'h1;
        end
    end
endmodule // sbcwk_timer

// *** src/sbcwk_top.v ***
// wake-up, mode sequencing, reset and watchdog output of the basis chip
`timescale 1ns/1ps
`include "sbcwk_regs.vh"

// What this block does
// - in sleep or stop, wake input change wakes; inputs readable.
// - cyclic sense pulses the high side switch; change then wakes.
// - cyclic sense and forced wake refuse each other.
// - forced wake enable wakes after a fixed low power time.
// - CAN wake-up is always active in low power modes.
// - rising serial select in sleep or stop wakes the device.
// - power-up wakes the device with no external event.
// - power-up or sleep wake go to reset, then normal request.
// - early supply warning interrupt, maskable, normal and standby only.
// - reset at power-up, sleep wake-up, regulator fall, watchdog expiry.
// - watchdog fault low with reset, high after watchdog write.
// - unconfigured after power-up, reset repeats each period.
// - mode write picks normal, standby or stop debug.
// - in debug no watchdog service and no watchdog reset.
// - writing 0000 to mode control leaves debug.
// - ground shift threshold selectable from four levels.
// - at transmit falling edge, low CAN high sets shift flag.
// - normal request: main on, tracking and switch off, reset pulse.
// - normal request timeout; timing write moves to normal.
// - battery fail flag set on low supply, cleared by read.
module sbcwk_top #(
    parameter [31:0] RST_PULSE_CYC = `SBCWK_T_RST_MS * `SBCWK_CLK_KHZ,
    parameter [31:0] NREQ_CYC      = `SBCWK_T_NREQ_MS * `SBCWK_CLK_KHZ,
    parameter [31:0] WD_CYC        = `SBCWK_T_WD_MS * `SBCWK_CLK_KHZ,
    parameter [31:0] FWU_CYC       = `SBCWK_T_FWU_MS * `SBCWK_CLK_KHZ,
    parameter [31:0] CS_PER_CYC    = `SBCWK_T_CS_PER_MS * `SBCWK_CLK_KHZ,
    parameter [31:0] CS_ON_CYC     = `SBCWK_T_CS_ON_MS * `SBCWK_CLK_KHZ
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output reg         ack_o,
    // wake and monitor pins
    input  wire        wake_input_a_i,
    input  wire        wake_input_b_i,
    input  wire        serial_select_n_i,
    input  wire        can_wake_i,
    input  wire        can_tx_i,
    input  wire [3:0]  canh_below_i,
    input  wire        vsup_warn_i,
    input  wire        vsup_batlow_i,
    input  wire        main_reg_ok_i,
    // supply and reset outputs
    output reg         main_regulator_en_o,
    output reg         tracking_regulator_en_o,
    output reg         high_side_switch_o,
    output reg         reset_n_o,
    output reg         watchdog_fault_n_o,
    output wire        early_warn_irq_o,
    output reg         debug_mode_o
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [5:0] ST_RESET = 6'h01;
    localparam [5:0] ST_NREQ  = 6'h02;
    localparam [5:0] ST_NORM  = 6'h04;
    localparam [5:0] ST_STBY  = 6'h08;
    localparam [5:0] ST_STOP  = 6'h10;
    localparam [5:0] ST_SLEEP = 6'h20;

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    wire [11:0] pins_s;
    sbcwk_sync #(.W(12)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({main_reg_ok_i, vsup_batlow_i, vsup_warn_i, canh_below_i,
                 can_tx_i, can_wake_i, serial_select_n_i,
                 wake_input_b_i, wake_input_a_i}),
        .q_o   (pins_s)
    );
    wire [1:0] wake_in_s  = pins_s[1:0];
    wire       sel_n_s    = pins_s[2];
    wire       can_wk_s   = pins_s[3];
    wire       tx_s       = pins_s[4];
    wire [3:0] below_s    = pins_s[8:5];
    wire       warn_s     = pins_s[9];
    wire       batlow_s   = pins_s[10];
    wire       reg_ok_s   = pins_s[11];

    reg        sel_n_q;
    reg        tx_q;
    reg        warn_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    reg [5:0]  state;
    reg [5:0]  next_state;
    wire       acc     = cyc_i && stb_i && !ack_o;
    wire       mapped  = (adr_i[7:5] == 3'h0) && (adr_i[1:0] == 2'h0);
    wire [2:0] idx     = adr_i[4:2];
    wire       wr_ok   = acc && we_i && sel_i[0] && mapped;
    wire       rd_ok   = acc && !we_i && mapped;
    wire [3:0] wd      = dat_i[3:0];

    function hit;
        input       ok;
        input [2:0] a;
        input [2:0] target;
        begin
            hit = ok && (a == target);
        end
    endfunction

    wire wr_mode  = hit(wr_ok, idx, `SBCWK_IDX_MODE);
    wire wr_wdtim = hit(wr_ok, idx, `SBCWK_IDX_WDTIM);
    wire rd_mode  = hit(rd_ok, idx, `SBCWK_IDX_MODE);
    wire rd_io    = hit(rd_ok, idx, `SBCWK_IDX_IO);
    wire rd_wake  = hit(rd_ok, idx, `SBCWK_IDX_WAKE);
    wire rd_rst   = hit(rd_ok, idx, `SBCWK_IDX_RSTCTL);
    wire rd_int   = hit(rd_ok, idx, `SBCWK_IDX_INT);

    // ------------------------------------------------------------------
    // control and status storage
    // ------------------------------------------------------------------
    reg        cs_en;
    reg        fwu_en;
    reg        hs_ctl;
    reg [1:0]  gsel;
    reg        wdstop;
    reg        ew_mask;
    reg        battery_fail_flag;
    reg        wdrst;
    reg        shift_flag;
    reg        ew_pend;
    reg        debug_armed;
    reg [1:0]  wake_ref;
    reg        src_input;
    reg        src_forced;
    reg        src_can;
    reg        src_select;
    reg        src_power;

    wire in_lp    = state[4] | state[5];
    wire mode_ok  = state[2] | state[3];
    wire wd_run   = (mode_ok || (state[4] && wdstop)) && !debug_mode_o;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    wire        mode_done;
    wire        wd_done;
    wire        lp_done;
    wire [31:0] lp_count;
    wire [31:0] mode_limit = state[0] ? RST_PULSE_CYC : NREQ_CYC;
    wire [31:0] lp_limit   = fwu_en ? FWU_CYC : CS_PER_CYC;
    wire        lp_wrap    = cs_en && lp_done;

    sbcwk_timer u_mode_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (next_state != state),
        .run_i     (state[0] | state[1]),
        .limit_i   (mode_limit),
        .count_o   (),
        .done_o    (mode_done)
    );

    sbcwk_timer u_wd_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (!wd_run || wr_wdtim || (next_state != state)),
        .run_i     (wd_run),
        .limit_i   (WD_CYC),
        .count_o   (),
        .done_o    (wd_done)
    );

    sbcwk_timer u_lp_tmr (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (!in_lp || lp_wrap),
        .run_i     (cs_en || fwu_en),
        .limit_i   (lp_limit),
        .count_o   (lp_count),
        .done_o    (lp_done)
    );

    // ------------------------------------------------------------------
    // wake detection
    // ------------------------------------------------------------------
    wire cs_on     = cs_en && in_lp && (lp_count < CS_ON_CYC);
    wire cs_sample = cs_en && in_lp && (lp_count == CS_ON_CYC - 32'h1);
    wire wk_input  = in_lp && (wake_in_s != wake_ref)
                     && (cs_en ? cs_sample : 1'b1);
    wire wk_forced = in_lp && fwu_en && lp_done;
    wire wk_can    = in_lp && can_wk_s;
    wire wk_select = in_lp && sel_n_s && !sel_n_q;
    wire wake_any  = wk_input | wk_forced | wk_can | wk_select;
    wire tx_fall   = tx_q && !tx_s;
    wire [2:0] mc  = wd[2:0];

    // ------------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (mode_done && reg_ok_s)
                    next_state = ST_NREQ;
            end
            ST_NREQ: begin
                if (!reg_ok_s)
                    next_state = ST_RESET;
                else if (wr_wdtim)
                    next_state = ST_NORM;
                else if (mode_done)
                    next_state = ST_RESET;
            end
            ST_NORM, ST_STBY: begin
                if (!reg_ok_s || (wd_run && wd_done))
                    next_state = ST_RESET;
                else if (wr_mode) begin
                    if (mc == `SBCWK_MC_NORMAL || mc == `SBCWK_MC_DBG_NORMAL)
                        next_state = ST_NORM;
                    else if (mc == `SBCWK_MC_STANDBY ||
                             mc == `SBCWK_MC_DBG_STBY)
                        next_state = ST_STBY;
                    else if (mc == `SBCWK_MC_STOP ||
                             mc == `SBCWK_MC_DBG_STOP)
                        next_state = ST_STOP;
                    else if (mc == `SBCWK_MC_SLEEP)
                        next_state = ST_SLEEP;
                end
            end
            ST_STOP: begin
                if (!reg_ok_s || (wd_run && wd_done))
                    next_state = ST_RESET;
                else if (wake_any)
                    next_state = ST_NREQ;
            end
            ST_SLEEP: begin
                if (wake_any)
                    next_state = ST_RESET;
            end
            default: next_state = ST_RESET;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // pins driven from the next mode
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            main_regulator_en_o     <= 1'b1;
            tracking_regulator_en_o <= 1'b0;
            high_side_switch_o      <= 1'b0;
            reset_n_o               <= 1'b0;
            watchdog_fault_n_o      <= 1'b0;
        end else begin
            main_regulator_en_o     <= (next_state != ST_SLEEP);
            tracking_regulator_en_o <= (next_state == ST_NORM);
            if (next_state == ST_NORM || next_state == ST_STBY)
                high_side_switch_o <= hs_ctl;
            else
                high_side_switch_o <= cs_on;
            reset_n_o <= !(next_state == ST_RESET ||
                           next_state == ST_SLEEP);
            // fault output drops in the same cycle as the reset pin
            if (next_state == ST_RESET || next_state == ST_SLEEP)
                watchdog_fault_n_o <= 1'b0;
            else if (wr_wdtim && reset_n_o)
                watchdog_fault_n_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // software writable control
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            cs_en        <= 1'b0;
            fwu_en       <= 1'b0;
            hs_ctl       <= 1'b0;
            gsel         <= `SBCWK_RST_GSEL;
            wdstop       <= `SBCWK_RST_WDSTOP;
            ew_mask      <= 1'b0;
            debug_armed  <= 1'b0;
            debug_mode_o <= 1'b0;
        end else begin
            if (hit(wr_ok, idx, `SBCWK_IDX_LOWPWR)) begin
                if (!wd[`SBCWK_LP_CS_BIT])
                    cs_en <= 1'b0;
                else if (!fwu_en)
                    cs_en <= 1'b1;
                if (!wd[`SBCWK_LP_FWU_BIT])
                    fwu_en <= 1'b0;
                else if (!cs_en && !wd[`SBCWK_LP_CS_BIT])
                    fwu_en <= 1'b1;
            end
            if (hit(wr_ok, idx, `SBCWK_IDX_IO)) begin
                hs_ctl <= wd[`SBCWK_IO_HS_BIT];
                gsel   <= wd[1:0];
            end
            if (hit(wr_ok, idx, `SBCWK_IDX_RSTCTL))
                wdstop <= wd[`SBCWK_RC_WDSTOP_BIT];
            if (hit(wr_ok, idx, `SBCWK_IDX_INT))
                ew_mask <= wd[`SBCWK_INT_EW_BIT];
            if (next_state == ST_RESET) begin
                debug_armed  <= 1'b0;
                debug_mode_o <= 1'b0;
            end else if (wr_mode && mode_ok) begin
                if (mc == `SBCWK_MC_DEBUG) begin
                    if (debug_mode_o || debug_armed) begin
                        debug_mode_o <= 1'b0;
                        debug_armed  <= 1'b0;
                    end else if (battery_fail_flag)
                        debug_armed <= 1'b1;
                end else if (mc[2] && mc != `SBCWK_MC_SLEEP &&
                             (debug_armed || debug_mode_o))
                    debug_mode_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // hardware flags, set wins over read clear
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            sel_n_q    <= 1'b0;
            tx_q       <= 1'b0;
            warn_q     <= 1'b0;
            battery_fail_flag    <= `SBCWK_RST_BATTERY_FAIL_FLAG;
            wdrst      <= 1'b0;
            shift_flag <= 1'b0;
            ew_pend    <= 1'b0;
            wake_ref   <= 2'h0;
            src_input  <= 1'b0;
            src_forced <= 1'b0;
            src_can    <= 1'b0;
            src_select <= 1'b0;
            src_power  <= 1'b1;
        end else begin
            sel_n_q <= sel_n_s;
            tx_q    <= tx_s;
            warn_q  <= warn_s;
            if (batlow_s)
                battery_fail_flag <= 1'b1;
            else if (rd_mode)
                battery_fail_flag <= 1'b0;
            if (wd_run && wd_done)
                wdrst <= 1'b1;
            else if (rd_mode)
                wdrst <= 1'b0;
            if (tx_fall && below_s[gsel])
                shift_flag <= 1'b1;
            else if (rd_io)
                shift_flag <= 1'b0;
            if (mode_ok && warn_s && !warn_q)
                ew_pend <= 1'b1;
            else if (rd_int)
                ew_pend <= 1'b0;
            if (!in_lp || cs_sample)
                wake_ref <= wake_in_s;
            if (wk_input)
                src_input <= 1'b1;
            else if (rd_wake)
                src_input <= 1'b0;
            if (wk_select)
                src_select <= 1'b1;
            else if (rd_wake)
                src_select <= 1'b0;
            if (wk_can)
                src_can <= 1'b1;
            else if (rd_rst)
                src_can <= 1'b0;
            if (wk_forced)
                src_forced <= 1'b1;
            else if (rd_int)
                src_forced <= 1'b0;
            if (rd_int)
                src_power <= 1'b0;
        end
    end

    assign early_warn_irq_o = ew_pend && ew_mask;

    // ------------------------------------------------------------------
    // bus answer and read data
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= acc;
            if (acc) begin
                dat_o <= 32'h0;
                if (!mapped || we_i)
                    dat_o <= 32'h0;
                else if (idx == `SBCWK_IDX_MODE)
                    dat_o[3:0] <= {battery_fail_flag, 2'h0, wdrst};
                else if (idx == `SBCWK_IDX_RSTCTL)
                    dat_o[3:0] <= {wdstop, 2'h0, src_can};
                else if (idx == `SBCWK_IDX_IO)
                    dat_o[3:0] <= {1'b0, hs_ctl, warn_s, shift_flag};
                else if (idx == `SBCWK_IDX_WAKE)
                    dat_o[3:0] <= {src_select, src_input, wake_in_s};
                else if (idx == `SBCWK_IDX_LOWPWR)
                    dat_o[3:0] <= {2'h0, fwu_en, cs_en};
                else if (idx == `SBCWK_IDX_INT)
                    dat_o[3:0] <= {ew_mask, src_power, src_forced, ew_pend};
            end
        end
    end
endmodule // sbcwk_top

// *** tb/sbcwk_chk.sv ***
// port assertions for the wake and mode control block
`timescale 1ns/1ps
module sbcwk_chk (
    input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire [31:0] dat_o,
    input wire        reset_n_o, watchdog_fault_n_o, debug_mode_o,
    input wire        main_regulator_en_o, tracking_regulator_en_o,
    input wire        high_side_switch_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_pulse; ack_o ##1 !ack_o; endsequence
    sequence s_rel; !reset_n_o ##1 reset_n_o; endsequence
    a_bus_ack: assert property (s_req |=> s_pulse)
        else $error("ack not one pulse after request");
    a_rd_upper: assert property (ack_o && !we_i |-> dat_o[31:4] == 28'h0)
        else $error("read data upper bits set");
    a_wdog_low: assert property (!reset_n_o |-> !watchdog_fault_n_o)
        else $error("watchdog fault high while reset low");
    a_wdog_rise: assert property ($rose(watchdog_fault_n_o) |->
        ack_o && $past(we_i) && reset_n_o)
        else $error("watchdog fault rose without a write");
    a_rst_hold: assert property ($fell(reset_n_o) |-> !reset_n_o[*8])
        else $error("reset pulse too short");
    a_nreq_out: assert property (s_rel |-> main_regulator_en_o &&
        !tracking_regulator_en_o && !high_side_switch_o)
        else $error("wrong supplies in normal request");
    a_trk_run: assert property (tracking_regulator_en_o |-> reset_n_o)
        else $error("tracking on during reset");
    a_dbg_run: assert property (debug_mode_o [*2] |-> reset_n_o)
        else $error("reset during debug");
endmodule // sbcwk_chk
bind sbcwk_top sbcwk_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .ack_o(ack_o), .dat_o(dat_o), .reset_n_o(reset_n_o),
    .watchdog_fault_n_o(watchdog_fault_n_o), .debug_mode_o(debug_mode_o),
    .main_regulator_en_o(main_regulator_en_o),
    .tracking_regulator_en_o(tracking_regulator_en_o),
    .high_side_switch_o(high_side_switch_o));

// *** tb/sbcwk_can.sv ***
// far-side CAN transceiver model: transmit line and level comparators
`timescale 1ns/1ps
module sbcwk_can (
    input  wire logic       en_i,
    input  wire logic [3:0] lvl_i,
    output logic            can_tx_o,
    output logic [3:0]      canh_below_o
);
    // transmit toggles only inside a frame, recessive high between
    initial can_tx_o = 1'b1;
    always #80 can_tx_o = en_i ? ~can_tx_o : 1'b1;
    assign canh_below_o = lvl_i;
endmodule // sbcwk_can

// *** tb/sbcwk_top_test.sv ***
// self-checking bench for the wake-up and mode control block
`timescale 1ns/1ps
module sbcwk_top_test;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wk_a = 0;
    logic wk_b = 0, sel_n = 1, can_wk = 0, can_en = 0, ok = 1, lo = 0;
    logic warn = 0;
    logic [7:0] adr_i = 0;
    logic [31:0] dat_i = 0;
    logic [3:0] sel_i = 0, lvl = 0, below;
    logic [15:0] r = 16'hd725;
    wire [31:0] dat_o;
    wire ack_o, tx, m_en, trk, hs, rst_n, wdf_n, irq, dbg;
    int err_count = 0, checks = 0, cyc_cnt = 0;
    logic [31:0] exp_q[$];
    always #4 clk_i = ~clk_i;
    sbcwk_top #(.RST_PULSE_CYC(20), .NREQ_CYC(200), .WD_CYC(150),
        .FWU_CYC(100), .CS_PER_CYC(60), .CS_ON_CYC(10)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .wake_input_a_i(wk_a),
        .wake_input_b_i(wk_b), .serial_select_n_i(sel_n),
        .can_wake_i(can_wk), .can_tx_i(tx), .canh_below_i(below),
        .vsup_warn_i(warn), .vsup_batlow_i(lo), .main_reg_ok_i(ok),
        .main_regulator_en_o(m_en), .tracking_regulator_en_o(trk),
        .high_side_switch_o(hs), .reset_n_o(rst_n),
        .watchdog_fault_n_o(wdf_n), .early_warn_irq_o(irq),
        .debug_mode_o(dbg));
    sbcwk_can i_can (.en_i(can_en), .lvl_i(lvl), .can_tx_o(tx),
        .canh_below_o(below));
    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic stop_test;
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input [31:0] e, input [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one classic cycle; a read notes its expected data for the monitor
    task automatic bus(input [7:0] a, input [3:0] d, input w);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, 4'hf};
        dat_i <= {28'h0, d};
        if (!w) exp_q.push_back({28'h0, d});
        do @(posedge clk_i); while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic wait_rst(input logic v);
        int n = 0;
        while (rst_n !== v && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        chk("reset_n", v, rst_n);
    endtask
    task automatic wake(input int k, input [7:0] a, input [3:0] e);
        bus(8'h00, 4'h3, 1);
        repeat (5) @(posedge clk_i);
        if (k == 0) sel_n <= 0;
        if (k == 1) can_wk <= 1;
        if (k == 2) wk_a <= 1;
        if (k == 4) wk_b <= 1;
        repeat (4) @(posedge clk_i);
        {sel_n, can_wk} <= 2'b10;
        repeat (110) @(posedge clk_i);
        bus(8'h14, 4'h0, 1);
        bus(a, e, 0);
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), dat_o);
        if (cyc_cnt == 20000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        wait_rst(1);
        chk("wdog_n", 0, wdf_n);
        chk("track", 0, trk);
        bus(8'h14, 4'h0, 1);
        @(posedge clk_i);
        chk("wdog_n", 1, wdf_n);
        chk("track", 1, trk);
        bus(8'h00, 4'h0, 1);
        bus(8'h00, 4'h5, 1);
        @(posedge clk_i);
        chk("debug", 1, dbg);
        repeat (250) @(posedge clk_i);
        chk("reset_n", 1, rst_n);
        bus(8'h14, 4'h0, 1);
        bus(8'h00, 4'h0, 1);
        @(posedge clk_i);
        chk("debug", 0, dbg);
        bus(8'h00, 4'h8, 0);
        bus(8'h00, 4'h0, 0);
        bus(8'h00, 4'h0, 1);
        bus(8'h00, 4'h5, 1);
        @(posedge clk_i);
        chk("debug", 0, dbg);
        bus(8'h1c, 4'h4, 0);
        bus(8'h18, 4'h3, 1);
        bus(8'h18, 4'h1, 0);
        bus(8'h18, 4'h0, 1);
        bus(8'h18, 4'h2, 1);
        bus(8'h18, 4'h3, 1);
        bus(8'h18, 4'h2, 0);
        wake(3, 8'h1c, 4'h2);
        bus(8'h18, 4'h0, 1);
        wake(0, 8'h10, 4'h8);
        wake(1, 8'h04, 4'h9);
        wake(2, 8'h10, 4'h5);
        bus(8'h18, 4'h1, 1);
        wake(4, 8'h10, 4'h7);
        {can_en, lvl} <= 5'h14;
        bus(8'h0c, 4'h6, 1);
        repeat (60) @(posedge clk_i);
        lvl <= 4'hb;
        repeat (4) @(posedge clk_i);
        bus(8'h0c, 4'h5, 0);
        bus(8'h1c, 4'h1, 1);
        warn <= 1;
        repeat (4) @(posedge clk_i);
        chk("irq", 1, irq);
        bus(8'h1c, 4'h9, 0);
        warn <= 0;
        chk("irq", 0, irq);
        bus(8'h14, 4'h0, 1);
        repeat (60) @(posedge clk_i);
        bus(8'h0c, 4'h4, 0);
        r = lfsr(r);
        bus({1'b1, r[6:2], 2'b00}, r[3:0], 1);
        bus({1'b1, r[6:2], 2'b00}, 4'h0, 0);
        wait_rst(0);
        wait_rst(1);
        chk("hs", 0, hs);
        bus(8'h00, 4'h1, 0);
        wait_rst(0);
        stop_test();
    end
endmodule // sbcwk_top_test
